/* File: rtl/osi_pkg.sv */
package osi_pkg;
    // register offsets on the device register port
    localparam logic [7:0] OSI_ADDR_CTRL1   = 8'h10;
    localparam logic [7:0] OSI_ADDR_STATUS  = 8'h13;
    localparam logic [7:0] OSI_ADDR_MASK    = 8'h14;
    localparam logic [7:0] OSI_ADDR_EDGE    = 8'h15;
    localparam logic [7:0] OSI_ADDR_LATCH   = 8'h16;

    // status field positions
    localparam int OSI_ST_BUS_VALID   = 0;
    localparam int OSI_ST_SESS_VALID  = 1;
    localparam int OSI_ST_SESS_END    = 2;
    localparam int OSI_ST_ID_GROUNDED      = 3;
    localparam int OSI_ST_ID_FLOATING    = 4;
    localparam int OSI_ST_A_NEG       = 5;
    localparam int OSI_ST_B_NEG       = 6;

    // control register 1 field positions
    localparam int OSI_C1_IRQ_PUSHPULL = 1;
    localparam int OSI_C1_NEG_CONN_EN  = 2;

    // latch field positions
    localparam int OSI_LT_BUS_RISE   = 0;
    localparam int OSI_LT_SESS_RISE  = 1;
    localparam int OSI_LT_BUS_FALL   = 2;
    localparam int OSI_LT_SESS_FALL  = 3;
    localparam int OSI_LT_SESS_END   = 4;
    localparam int OSI_LT_ID_GROUNDED     = 5;
    localparam int OSI_LT_ID_FLOATING   = 6;
    localparam int OSI_LT_NEG        = 7;

    // writable bit masks and reset values
    localparam logic [7:0] OSI_CTRL1_WMASK = 8'h06;
    localparam logic [7:0] OSI_MASK_WMASK  = 8'h3f;
    localparam logic [7:0] OSI_EDGE_WMASK  = 8'h03;
    localparam logic [7:0] OSI_CTRL1_RST   = 8'h00;
    localparam logic [7:0] OSI_MASK_RST    = 8'h00;
    localparam logic [7:0] OSI_EDGE_RST    = 8'h00;
    localparam logic [7:0] OSI_LATCH_RST   = 8'h00;
    localparam logic [1:0] OSI_NEG_RST     = 2'h0;
endpackage

/* File: rtl/osi_status_irq.sv */
`timescale 1ns/1ns
// Operation
// - status bit0 follows bus-valid comparator
// - status bit2 high when below session-end
// - status bit3 reads identification grounded
// - status bit4 reads identification floating
// - bit5 set on A-side negotiation, sticky
// - bit6 set on B-side SE0, sticky
// - status at 13h, bits 7..5 reset zero
// - mask, edge, latch reset to zero
// - mask bits 0..5 enable each source
// - edge bit0 picks bus-valid edge
// - edge bit1 picks session-valid edge
// - latch bits record each pending request
// - control1 bit2 gates negotiation flags
// - control1 bit1 picks open-drain or push-pull
module osi_status_irq
(
    input  wire logic       clk_i,              // 100 MHz device clock
    input  wire logic       rstn_i,             // async power-up reset, active low
    input  wire logic [7:0] reg_addr_i,         // register address
    input  wire logic       reg_wr_i,           // write strobe, one cycle
    input  wire logic [7:0] reg_wdata_i,        // write data
    input  wire logic       reg_rd_i,           // read strobe, one cycle
    output logic      [7:0] reg_rdata_o,        // read data, registered
    input  wire logic       bus_valid_i,        // bus-valid comparator
    input  wire logic       session_valid_i,    // session-valid comparator
    input  wire logic       session_end_i,      // high when bus below session-end level
    input  wire logic       id_grounded_i,      // identification detector: grounded
    input  wire logic       id_floating_i,      // identification detector: floating
    input  wire logic       a_device_i,         // device acts as A-device
    input  wire logic       negotiation_i,      // host negotiation in progress
    input  wire logic       partner_pullup_i,   // partner attached its pullup
    input  wire logic       se0_i,              // SE0 seen on the data lines
    output logic            irq_n_o,            // interrupt pin level, active low
    output logic            irq_oe_o            // interrupt pin output enable
);
    import osi_pkg::*;

    logic [7:0] ctrl1_q;        // control register 1 (bits 1, 2 only)
    logic [7:0] mask_q;         // interrupt enable mask
    logic [7:0] edge_q;         // edge select
    logic [7:0] latch_q;        // pending requests
    logic [7:0] latch_d;        // next pending requests
    logic [1:0] neg_q;          // a-side / b-side negotiation flags
    logic [1:0] neg_d;          // next negotiation flags
    logic [4:0] prev_q;         // last sampled detector bits
    logic       prev_ok_q;      // prev_q holds a real sample
    logic [7:0] rdata_d;        // read mux

    // live status image, bit 7 unused
    wire [7:0] status_w = {1'b0, neg_q, id_floating_i, id_grounded_i,
                           session_end_i, session_valid_i, bus_valid_i};

    // decode of write strobes and the latch read strobe
    wire wr_ctrl1_w = reg_wr_i && (reg_addr_i == OSI_ADDR_CTRL1);
    wire wr_mask_w  = reg_wr_i && (reg_addr_i == OSI_ADDR_MASK);
    wire wr_edge_w  = reg_wr_i && (reg_addr_i == OSI_ADDR_EDGE);
    wire rd_latch_w = reg_rd_i && (reg_addr_i == OSI_ADDR_LATCH);

    wire neg_en_w = ctrl1_q[OSI_C1_NEG_CONN_EN];
    wire a_set_w  = neg_en_w && a_device_i && negotiation_i && partner_pullup_i;
    wire b_set_w  = neg_en_w && !a_device_i && negotiation_i && se0_i;

    // flags hold until software drops the enable; while it is low they cannot set
    // the b-side flag raises no request of its own: only the a-side event owns a latch bit
    assign neg_d = neg_en_w ? (neg_q | {b_set_w, a_set_w}) : OSI_NEG_RST;

    // edge detection; first sample after reset raises nothing since the level is unknown
    // limitation: a detector pulse narrower than one clock can be missed, so the
    // comparator outputs are expected to be filtered before they reach this block
    wire [4:0] rise_w = prev_ok_q ? (status_w[4:0] & ~prev_q) : 5'h00;
    wire [4:0] fall_w = prev_ok_q ? (~status_w[4:0] & prev_q) : 5'h00;
    wire       neg_rise_w = neg_d[0] && !neg_q[0];

    // raw request events, one per latch bit
    wire [7:0] event_w = {
        neg_rise_w,
        rise_w[OSI_ST_ID_FLOATING],
        rise_w[OSI_ST_ID_GROUNDED],
        rise_w[OSI_ST_SESS_END],
        fall_w[OSI_ST_SESS_VALID] && !edge_q[OSI_ST_SESS_VALID],
        fall_w[OSI_ST_BUS_VALID]  && !edge_q[OSI_ST_BUS_VALID],
        rise_w[OSI_ST_SESS_VALID] &&  edge_q[OSI_ST_SESS_VALID],
        rise_w[OSI_ST_BUS_VALID]  &&  edge_q[OSI_ST_BUS_VALID]
    };

    // reading the latch clears it; a new event in that cycle wins over the clear
    assign latch_d = (rd_latch_w ? OSI_LATCH_RST : latch_q) | event_w;

    // each mask bit covers its source; edge sources own two latch bits
    wire [7:0] mask_exp_w = {mask_q[5], mask_q[4], mask_q[3], mask_q[2],
                             mask_q[1], mask_q[0], mask_q[1], mask_q[0]};
    wire       irq_act_w  = |(latch_q & mask_exp_w);

    // open drain only pulls low; push-pull drives both levels
    assign irq_n_o  = !irq_act_w;
    assign irq_oe_o = ctrl1_q[OSI_C1_IRQ_PUSHPULL] || irq_act_w;

    // read mux; unmapped addresses read zero
    // the mux is sampled into reg_rdata_o so the host sees one stable value per read
    assign rdata_d = (reg_addr_i == OSI_ADDR_CTRL1)  ? ctrl1_q  :
                     (reg_addr_i == OSI_ADDR_STATUS) ? status_w :
                     (reg_addr_i == OSI_ADDR_MASK)   ? mask_q   :
                     (reg_addr_i == OSI_ADDR_EDGE)   ? edge_q   :
                     (reg_addr_i == OSI_ADDR_LATCH)  ? latch_q  : 8'h00;

    // software registers, unused bits forced to zero
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl1_q <= OSI_CTRL1_RST;
            mask_q  <= OSI_MASK_RST;
            edge_q  <= OSI_EDGE_RST;
        end else begin
            if (wr_ctrl1_w) ctrl1_q <= reg_wdata_i & OSI_CTRL1_WMASK;
            if (wr_mask_w)  mask_q  <= reg_wdata_i & OSI_MASK_WMASK;
            if (wr_edge_w)  edge_q  <= reg_wdata_i & OSI_EDGE_WMASK;
        end
    end

    // hardware state: latch, negotiation flags, edge history, read data
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latch_q     <= OSI_LATCH_RST;
            neg_q       <= OSI_NEG_RST;
            prev_q      <= 5'h00;
            prev_ok_q   <= 1'b0;
            reg_rdata_o <= 8'h00;
        end else begin
            latch_q     <= latch_d;
            neg_q       <= neg_d;
            prev_q      <= status_w[4:0];
            prev_ok_q   <= 1'b1;
            reg_rdata_o <= reg_rd_i ? rdata_d : reg_rdata_o;
        end
    end

    // checks
    AST_BUS_RISE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prev_ok_q && edge_q[0] && $rose(bus_valid_i)) |=> latch_q[OSI_LT_BUS_RISE])
        else $error("bus-valid rise not latched");
    AST_BUS_FALL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prev_ok_q && !edge_q[0] && $fell(bus_valid_i)) |=> latch_q[OSI_LT_BUS_FALL])
        else $error("bus-valid fall not latched");
    AST_SESS_EDGE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (edge_q[1] && $fell(session_valid_i) && !latch_q[OSI_LT_SESS_FALL] && !rd_latch_w)
        |=> !latch_q[OSI_LT_SESS_FALL])
        else $error("session fall latched on rising select");
    AST_STATUS: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_rd_i && reg_addr_i == OSI_ADDR_STATUS)
        |=> reg_rdata_o[4:0] == $past(status_w[4:0]) && reg_rdata_o[7] == 1'b0)
        else $error("status read mismatch");
    AST_NEG_CLEAR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !neg_en_w |=> neg_q == 2'h0)
        else $error("negotiation flag kept without enable");
    AST_NEG_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (neg_q[1] && neg_en_w) |=> neg_q[1])
        else $error("b-side flag dropped while enabled");
    AST_IRQ: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (latch_q[OSI_LT_ID_GROUNDED] && mask_q[3]) |-> (!irq_n_o && irq_oe_o))
        else $error("enabled request does not drive interrupt");
    AST_OD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (!ctrl1_q[OSI_C1_IRQ_PUSHPULL] && irq_n_o) |-> !irq_oe_o)
        else $error("open drain drives high");
    AST_UNUSED: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_mask_w |=> mask_q[7:6] == 2'h0 && edge_q[7:2] == 6'h00)
        else $error("unused bits stored");
    AST_LATCH_CLR: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (rd_latch_w && event_w == 8'h00) |=> latch_q == 8'h00)
        else $error("latch not cleared by read");
    AST_LATCH_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !rd_latch_w |=> ((latch_q & $past(latch_q)) == $past(latch_q)))
        else $error("pending request lost without a read");

    // session edge select: the chosen transition must land in its own latch bit
    AST_SESS_RISE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prev_ok_q && edge_q[1] && $rose(session_valid_i)) |=> latch_q[OSI_LT_SESS_RISE])
        else $error("session rise not latched");
    AST_SESS_FALL: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prev_ok_q && !edge_q[1] && $fell(session_valid_i)) |=> latch_q[OSI_LT_SESS_FALL])
        else $error("session fall not latched");

    // level sources latch when their status bit becomes true
    AST_END_REQ: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prev_ok_q && $rose(session_end_i)) |=> latch_q[OSI_LT_SESS_END])
        else $error("session end not latched");
    AST_GND_REQ: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prev_ok_q && $rose(id_grounded_i)) |=> latch_q[OSI_LT_ID_GROUNDED])
        else $error("id grounded not latched");
    AST_FLOAT_REQ: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (prev_ok_q && $rose(id_floating_i)) |=> latch_q[OSI_LT_ID_FLOATING])
        else $error("id floating not latched");
    AST_NEG_REQ: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(neg_q[0]) |-> latch_q[OSI_LT_NEG])
        else $error("negotiation request not latched");

    // negotiation flags set from the raw role and line inputs
    AST_A_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ctrl1_q[OSI_C1_NEG_CONN_EN] && a_device_i && negotiation_i && partner_pullup_i) |=> neg_q[0])
        else $error("a-side flag not set");
    AST_B_SET: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (ctrl1_q[OSI_C1_NEG_CONN_EN] && !a_device_i && negotiation_i && se0_i) |=> neg_q[1])
        else $error("b-side flag not set");

    // interrupt pin: only a masked-in request may pull it, and idle means high, driven only in push-pull
    AST_MASK_GATE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !irq_n_o |-> (|(latch_q[7:4] & mask_q[5:2]) || |(latch_q[3:0] & {mask_q[1:0], mask_q[1:0]})))
        else $error("interrupt without enabled request");
    AST_PP: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl1_q[OSI_C1_IRQ_PUSHPULL] |-> irq_oe_o)
        else $error("push-pull pin not driven");
    AST_IRQ_IDLE: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (latch_q == 8'h00) |-> (irq_n_o && irq_oe_o == ctrl1_q[OSI_C1_IRQ_PUSHPULL]))
        else $error("interrupt active with nothing pending");

    // read path: flags reach the status image and read data holds between reads
    AST_STATUS_NEG: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (reg_rd_i && reg_addr_i == OSI_ADDR_STATUS) |=> reg_rdata_o[6:5] == $past(neg_q))
        else $error("negotiation flags not in status read");
    AST_READ_HOLD: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data changed without a read");

    // main scenarios to be seen at least once
    COV_IRQ:    cover property (@(posedge clk_i) disable iff (!rstn_i) $fell(irq_n_o));
    COV_NEG:    cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(neg_q[0]));
    COV_SETCLR: cover property (@(posedge clk_i) disable iff (!rstn_i) rd_latch_w && |event_w);
    COV_BFLAG:  cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(neg_q[1]));
    COV_SFALL:  cover property (@(posedge clk_i) disable iff (!rstn_i) $rose(latch_q[OSI_LT_SESS_FALL]));
endmodule

/* File: tb/osi_host_model.sv */
`timescale 1ns/1ns
// host side of the parallel register port: one strobe per access, changed 1 ns after an edge
module osi_host_model (
    input  wire logic       clk_i,       // device clock
    output logic      [7:0] reg_addr_o,  // register address
    output logic            reg_wr_o,    // write strobe
    output logic      [7:0] reg_wdata_o, // write data
    output logic            reg_rd_o,    // read strobe
    input  wire logic [7:0] reg_rdata_i  // registered read data
);
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end
    // held for one sampling edge; idle lines get inverted so a stale value never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1 {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
        @(posedge clk_i);
        #1 {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
    endtask
    // data is registered at the taking edge, so it is picked up just after it
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1 {reg_addr_o, reg_rd_o} = {a, 1'b1};
        @(posedge clk_i);
        #1 {reg_addr_o, reg_rd_o} = {~a, 1'b0};
        d = reg_rdata_i;
    endtask
endmodule

/* File: tb/otg_status_interrupt_logic_bench.sv */
`timescale 1ns/1ns
// register, detector and interrupt scenarios for the status block
module otg_status_interrupt_logic_bench;
    import osi_pkg::*;
    logic       clk_i, rstn_i;          // clock and active-low reset
    logic [7:0] addr, wdata, rdata, v;  // register port and last read value
    logic       wr, rd, irq_n, irq_oe;  // strobes and interrupt pin
    logic [8:0] det;                    // pullup, se0, negotiation, a-role, float, gnd, end, session, bus
    int         fails, samples_checked; // mismatch and comparison counts
    osi_status_irq dut (.clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .bus_valid_i(det[0]), .session_valid_i(det[1]), .session_end_i(det[2]),
        .id_grounded_i(det[3]), .id_floating_i(det[4]), .a_device_i(det[5]), .negotiation_i(det[6]),
        .se0_i(det[7]), .partner_pullup_i(det[8]), .irq_n_o(irq_n), .irq_oe_o(irq_oe));
    osi_host_model host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata), .reg_rd_o(rd),
        .reg_rdata_i(rdata));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, v);
        chk(v, e);
    endtask
    // detector levels change after an edge; two edges let the request land
    task automatic sd(input logic [8:0] d);
        @(posedge clk_i);
        #1 det = d;
        repeat (2) @(posedge clk_i);
        #1;
    endtask
    task automatic t_reset();
        rc(OSI_ADDR_MASK, 8'h00);
        rc(OSI_ADDR_EDGE, 8'h00);
        rc(OSI_ADDR_LATCH, 8'h00);
        rc(8'h20, 8'h00);
        host.rd(OSI_ADDR_STATUS, v);
        chk(v & 8'he0, 8'h00);
        chk({6'h00, irq_oe, irq_n}, 8'h01);
    endtask
    task automatic t_regs();
        host.wr(OSI_ADDR_MASK, 8'hff);
        rc(OSI_ADDR_MASK, 8'h3f);
        host.wr(OSI_ADDR_EDGE, 8'hff);
        rc(OSI_ADDR_EDGE, 8'h03);
        host.wr(OSI_ADDR_MASK, 8'h00);
    endtask
    task automatic t_status();
        sd(9'h015);
        rc(OSI_ADDR_STATUS, 8'h15);
        sd(9'h00a);
        rc(OSI_ADDR_STATUS, 8'h0a);
        sd(9'h000);
        rc(OSI_ADDR_LATCH, 8'h73);
    endtask
    // edge select picks which comparator transition is latched; the wrong one is refused
    task automatic t_edges();
        host.wr(OSI_ADDR_MASK, 8'h03);
        sd(9'h003);
        chk({6'h00, irq_oe, irq_n}, 8'h02);
        rc(OSI_ADDR_LATCH, 8'h03);
        chk({7'h00, irq_n}, 8'h01);
        sd(9'h000);
        rc(OSI_ADDR_LATCH, 8'h00);
        host.wr(OSI_ADDR_EDGE, 8'h00);
        sd(9'h003);
        sd(9'h000);
        rc(OSI_ADDR_LATCH, 8'h0c);
    endtask
    task automatic t_other();
        host.wr(OSI_ADDR_MASK, 8'h00);
        sd(9'h01c);
        chk({7'h00, irq_n}, 8'h01);
        host.wr(OSI_ADDR_MASK, 8'h1c);
        chk({7'h00, irq_n}, 8'h00);
        rc(OSI_ADDR_LATCH, 8'h70);
        chk({7'h00, irq_n}, 8'h01);
        sd(9'h000);
        rc(OSI_ADDR_LATCH, 8'h00);
    endtask
    // negotiation flags need the enable, then stick until it is written back to zero
    task automatic t_neg();
        sd(9'h160);
        rc(OSI_ADDR_STATUS, 8'h00);
        sd(9'h000);
        host.wr(OSI_ADDR_MASK, 8'h20);
        host.wr(OSI_ADDR_CTRL1, 8'h04);
        rc(OSI_ADDR_STATUS, 8'h00);
        sd(9'h160);
        sd(9'h000);
        rc(OSI_ADDR_STATUS, 8'h20);
        chk({6'h00, irq_oe, irq_n}, 8'h02);
        rc(OSI_ADDR_LATCH, 8'h80);
        host.wr(OSI_ADDR_CTRL1, 8'h00);
        rc(OSI_ADDR_STATUS, 8'h00);
        host.wr(OSI_ADDR_CTRL1, 8'h04);
        sd(9'h0c0);
        sd(9'h000);
        rc(OSI_ADDR_STATUS, 8'h40);
        host.wr(OSI_ADDR_CTRL1, 8'h02);
        rc(OSI_ADDR_STATUS, 8'h00);
        chk({6'h00, irq_oe, irq_n}, 8'h03);
    endtask
    task automatic end_sim();
        if (fails == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        {fails, samples_checked} = '0;
        det = 9'h000;
        rstn_i = 1'b0;
        repeat (3) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        t_reset();
        t_regs();
        t_status();
        t_edges();
        t_other();
        t_neg();
        end_sim();
    end
    // the scenarios need well under 2000 cycles
    initial begin
        #40000;
        fails++;
        end_sim();
    end
endmodule
